// >>> logic/mbp_pkg.sv
// Constants and types for the poll list command interpreter
`default_nettype none
package mbp_pkg;
	// Register byte offsets on the APB side
	localparam logic [11:0] CTRL_OFS = 12'h000; // Command control word
	localparam logic [11:0] STAT_OFS = 12'h004; // Command status word
	localparam logic [11:0] CFG_OFS  = 12'h008; // Active port settings
	localparam logic [1:0]  MEM_SEL  = 2'h1;    // PADDR[11:10] of memory window
	// Control word fields and reset value
	localparam int          CTL_TRIG = 0;       // Trigger level
	localparam int          CTL_COUP = 1;       // trigger_coupling_select
	localparam int          CTL_ACK  = 2;       // Error acknowledge
	localparam int          CTL_BASE = 8;       // Block address, 8 bits
	localparam logic [31:0] CTRL_RST = 32'h0;
	// Status word fields
	localparam int          STA_BUSY = 0;       // slot_busy_flag
	localparam int          STA_ERR  = 1;       // slot_error_flag
	// Command codes and field values
	localparam logic [15:0] CMD_CREATE  = 16'h0001;
	localparam logic [15:0] CMD_POLL    = 16'h2804;
	localparam logic [15:0] HANDLER_RTU = 16'h0028;
	localparam logic [15:0] PAR_EVEN    = 16'h0002; // Highest parity code
	localparam logic [15:0] HS_NONE     = 16'h0000;
	localparam logic [15:0] HS_RS485    = 16'h0004;
	localparam logic [15:0] NUM_PORTS   = 16'h0004;
	// Word offsets inside a request block
	localparam logic [7:0] W_ERR = 8'h00, W_CMD = 8'h01, W_CONN = 8'h02;
	localparam logic [7:0] W_HANDLER = 8'h03, W_PORT = 8'h04, W_BAUD = 8'h05;
	localparam logic [7:0] W_PARITY = 8'h07, W_HS = 8'h09, W_OPT = 8'h0a;
	localparam logic [7:0] W_MODEM = 8'h0b;
	localparam logic [7:0] W_FLAGS = 8'h03, W_TMO = 8'h04, W_ERRLOC = 8'h05;
	localparam logic [7:0] W_LEN = 8'h06, W_LIST = 8'h07;
	// Word offsets inside a query block
	localparam logic [7:0] QB_FLAGS = 8'h01, QB_SLAVE = 8'h04, QB_FUNC = 8'h05;
	// Flag bit positions (MSB-first bit 16 is LSB 0, bit 15 is LSB 1)
	localparam int FLG_STOP_PROTO = 0;
	localparam int QF_STOP_EXC    = 1;
	// Error codes written to the error word
	localparam logic [15:0] ERR_NONE  = 16'h0000;
	localparam logic [15:0] ERR_CMD   = 16'h0001;
	localparam logic [15:0] ERR_PM    = 16'h0002;
	localparam logic [15:0] ERR_PARAM = 16'h0003;
	localparam logic [15:0] ERR_CONN  = 16'h0004;
	localparam logic [15:0] ERR_QUERY = 16'h0005;
	// Query outcome codes from the RTU engine
	localparam logic [1:0] QS_OK = 2'h0, QS_PROTO = 2'h1, QS_EXC = 2'h2;
	// Timing
	localparam int          CLK_HZ      = 25000000; // Reference clock rate
	localparam int          TMO_UNIT_S  = 1;        // Timeout field unit, seconds
	localparam int          CYC_PER_SEC = TMO_UNIT_S * CLK_HZ;
	localparam logic [15:0] DEF_TMO_S   = 16'h0001; // Used when field is zero
	// Active connection settings
	typedef struct packed {
		logic        up;
		logic [15:0] conn;
		logic [15:0] port;
		logic [15:0] baud;
		logic [1:0]  parity;
		logic        rs485;
		logic        std_timing;
		logic        modem_en;
		logic [15:0] modem_tab;
	} mbp_cfg_t;
	// Interpreter states
	typedef enum logic [2:0] {
		S_IDLE, S_DECODE, S_CREATE, S_POLL, S_QNEXT, S_QWAIT, S_ERRLOC, S_FINISH
	} mbp_state_t;
endpackage
`default_nettype wire

// >>> logic/mbp_poll_list.sv
// Command interpreter for connection creation and RTU poll lists
// Notes on behaviour
// - Create uses code 1, handler 0x28
// - Bind the named physical port
// - Baud field is plain binary rate
// - Parity: 0 none, 1 odd, 2 even
// - Handshake: 0 none, 4 RS-485
// - Zero modem table address: no modem
// - Poll start code 0x2804 runs queries
// - Flag bit16 stops on protocol error
// - Per-query timeout in seconds
// - Halt writes failing query block address
// - Run length-word count of listed queries
// - Query flag bit15 stops on exception
// - Acknowledge clears error and busy
// - Coupled mode: one run per trigger rise
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mbp_poll_list #(
	parameter int unsigned CYC_PER_SEC = mbp_pkg::CYC_PER_SEC // Cycles per second
) (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             QRY_START_O,
	output logic      [7:0]  QRY_BLOCK_O,
	output logic      [7:0]  QRY_SLAVE_O,
	output logic      [7:0]  QRY_FUNC_O,
	input  wire logic        QRY_DONE_I,
	input  wire logic [1:0]  QRY_STATUS_I,
	output logic             CONN_UP_O,
	output logic      [15:0] PORT_NUM_O,
	output logic      [15:0] BAUD_O,
	output logic      [1:0]  PARITY_O,
	output logic             RS485_O,
	output logic             STD_TIMING_O,
	output logic             MODEM_EN_O,
	output logic      [15:0] MODEM_TAB_O,
	output logic             POLL_RUN_O
);
	logic [15:0]          mem_q [256];      // Command and query block memory
	mbp_pkg::mbp_state_t  st_q, st_d;       // Interpreter state
	mbp_pkg::mbp_cfg_t    cfg_q, cfg_d;     // Active connection
	logic [31:0]          ctrl_q, ctrl_d;   // command_control_word
	logic [31:0]          prdata_q, prdata_d;
	logic [7:0]           base_q, base_d;   // Block being executed
	logic [15:0]          idx_q, idx_d;     // Position in the query list
	logic [15:0]          len_q, len_d;     // Query list length
	logic                 stop_q, stop_d;   // Stop on protocol error
	logic                 qstop_q, qstop_d; // Stop on exception, this query
	logic [15:0]          tmo_q, tmo_d;     // Timeout, seconds
	logic [15:0]          sec_q, sec_d;     // Seconds elapsed
	logic [31:0]          cyc_q, cyc_d;     // Cycles within the second
	logic [15:0]          code_q, code_d;   // Pending error code
	logic                 busy_q, busy_d;   // slot_busy_flag
	logic                 err_q, err_d;     // slot_error_flag
	logic                 armed_q, armed_d; // Trigger seen low
	logic                 start_q, start_d; // Query start pulse
	logic [7:0]           qblk_q, qblk_d;   // Current query block
	logic [7:0]           slv_q, slv_d;
	logic [7:0]           fn_q, fn_d;
	logic                 fsm_we;           // Interpreter writes memory
	logic [7:0]           fsm_wa;
	logic [15:0]          fsm_wd;
	logic                 apb_go;           // Access completes this edge
	logic                 mem_hit;          // Address in memory window
	logic                 mapped;
	logic                 trig;
	logic                 go;
	logic                 halt;
	logic                 fail;
	logic [31:0]          rd_mux;

	// Block word fetch relative to a given block address, the executing block or a query block
	function automatic logic [15:0] blk(input logic [7:0] b, input logic [7:0] ofs);
		logic [7:0] a;
		a = b + ofs;
		return mem_q[a];
	endfunction

	// Bus decode; each interpreter memory write stalls the bus one cycle, two in a row after a halt
	assign mem_hit   = (PADDR_I[11:10] == mbp_pkg::MEM_SEL);
	assign mapped    = mem_hit || PADDR_I == mbp_pkg::CTRL_OFS
		|| PADDR_I == mbp_pkg::STAT_OFS || PADDR_I == mbp_pkg::CFG_OFS;
	assign PREADY_O  = PENABLE_I && !fsm_we;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !fsm_we && !mapped;
	assign apb_go    = PSEL_I && PENABLE_I && PREADY_O && mapped;
	assign PRDATA_O  = prdata_q;

	// Read mux; data is sampled each cycle PSEL_I is high so it is settled at access
	always_comb
	begin
		rd_mux = 32'h0;
		if (mem_hit)
			rd_mux = {16'h0, mem_q[PADDR_I[9:2]]};
		else if (PADDR_I == mbp_pkg::CTRL_OFS)
			rd_mux = ctrl_q;
		else if (PADDR_I == mbp_pkg::STAT_OFS)
			rd_mux = {code_q, 14'h0, err_q, busy_q};
		else if (PADDR_I == mbp_pkg::CFG_OFS)
			rd_mux = {cfg_q.baud, cfg_q.port[7:0], 1'h0, cfg_q.up, cfg_q.modem_en,
				cfg_q.std_timing, cfg_q.rs485, 1'h0, cfg_q.parity};
		prdata_d = PSEL_I ? rd_mux : prdata_q;
		ctrl_d   = ctrl_q;
		if (apb_go && PWRITE_I && PADDR_I == mbp_pkg::CTRL_OFS)
			ctrl_d = PWDATA_I;
	end

	// Trigger qualification
	assign trig = ctrl_q[mbp_pkg::CTL_TRIG];
	assign go   = trig && !busy_q && !err_q && (!ctrl_q[mbp_pkg::CTL_COUP] || armed_q);

	// Query outcome: timeouts count as failures
	assign fail = (st_q == mbp_pkg::S_QWAIT) && ((QRY_DONE_I && QRY_STATUS_I == mbp_pkg::QS_PROTO)
		|| (!QRY_DONE_I && sec_q >= tmo_q));
	assign halt = (fail && stop_q)
		|| (QRY_DONE_I && st_q == mbp_pkg::S_QWAIT && QRY_STATUS_I == mbp_pkg::QS_EXC && qstop_q);

	// Interpreter next state
	always_comb
	begin
		st_d    = st_q;
		cfg_d   = cfg_q;
		base_d  = base_q;
		idx_d   = idx_q;
		len_d   = len_q;
		stop_d  = stop_q;
		qstop_d = qstop_q;
		tmo_d   = tmo_q;
		sec_d   = sec_q;
		cyc_d   = cyc_q;
		code_d  = code_q;
		busy_d  = busy_q;
		err_d   = err_q;
		start_d = 1'b0;
		qblk_d  = qblk_q;
		slv_d   = slv_q;
		fn_d    = fn_q;
		fsm_we  = 1'b0;
		fsm_wa  = base_q;
		fsm_wd  = code_q;
		// Re-arm once the trigger drops
		armed_d = armed_q || !trig;
		unique case (st_q)
			mbp_pkg::S_IDLE:
			begin
				// Acknowledge drops both indications
				if (err_q && ctrl_q[mbp_pkg::CTL_ACK])
				begin
					err_d  = 1'b0;
					busy_d = 1'b0;
				end
				else if (go)
				begin
					base_d  = ctrl_q[mbp_pkg::CTL_BASE +: 8];
					busy_d  = 1'b1;
					armed_d = 1'b0;
					code_d  = mbp_pkg::ERR_NONE;
					st_d    = mbp_pkg::S_DECODE;
				end
			end
			mbp_pkg::S_DECODE:
			begin
				// Dispatch on the command word
				if (blk(base_q, mbp_pkg::W_CMD) == mbp_pkg::CMD_CREATE)
					st_d = mbp_pkg::S_CREATE;
				else if (blk(base_q, mbp_pkg::W_CMD) == mbp_pkg::CMD_POLL)
					st_d = mbp_pkg::S_POLL;
				else
				begin
					code_d = mbp_pkg::ERR_CMD;
					st_d   = mbp_pkg::S_FINISH;
				end
			end
			mbp_pkg::S_CREATE:
			begin
				st_d = mbp_pkg::S_FINISH;
				// Only the RTU master handler is served here
				if (blk(base_q, mbp_pkg::W_HANDLER) != mbp_pkg::HANDLER_RTU)
					code_d = mbp_pkg::ERR_PM;
				else if (blk(base_q, mbp_pkg::W_PORT) == 16'h0
					|| blk(base_q, mbp_pkg::W_PORT) > mbp_pkg::NUM_PORTS
					|| blk(base_q, mbp_pkg::W_BAUD) == 16'h0
					|| blk(base_q, mbp_pkg::W_PARITY) > mbp_pkg::PAR_EVEN
					|| (blk(base_q, mbp_pkg::W_HS) != mbp_pkg::HS_NONE
					&& blk(base_q, mbp_pkg::W_HS) != mbp_pkg::HS_RS485))
					code_d = mbp_pkg::ERR_PARAM;
				else
				begin
					// Reserved words are not inspected; they are assumed zero
					cfg_d.up         = 1'b1;
					cfg_d.conn       = blk(base_q, mbp_pkg::W_CONN);
					cfg_d.port       = blk(base_q, mbp_pkg::W_PORT);
					cfg_d.baud       = blk(base_q, mbp_pkg::W_BAUD);
					cfg_d.parity     = 2'(blk(base_q, mbp_pkg::W_PARITY));
					cfg_d.rs485      = blk(base_q, mbp_pkg::W_HS) == mbp_pkg::HS_RS485;
					cfg_d.std_timing = blk(base_q, mbp_pkg::W_OPT) == 16'h0;
					cfg_d.modem_tab  = blk(base_q, mbp_pkg::W_MODEM);
					// Dialing needs a nonzero option word and a modem table
					cfg_d.modem_en   = blk(base_q, mbp_pkg::W_OPT) != 16'h0
						&& blk(base_q, mbp_pkg::W_MODEM) != 16'h0;
				end
			end
			mbp_pkg::S_POLL:
			begin
				// Connection must match the one created
				if (!cfg_q.up || blk(base_q, mbp_pkg::W_CONN) != cfg_q.conn)
				begin
					code_d = mbp_pkg::ERR_CONN;
					st_d   = mbp_pkg::S_FINISH;
				end
				else
				begin
					stop_d = 1'(blk(base_q, mbp_pkg::W_FLAGS) >> mbp_pkg::FLG_STOP_PROTO);
					tmo_d  = (blk(base_q, mbp_pkg::W_TMO) == 16'h0) ? mbp_pkg::DEF_TMO_S
						: blk(base_q, mbp_pkg::W_TMO);
					len_d  = blk(base_q, mbp_pkg::W_LEN);
					idx_d  = 16'h0;
					st_d   = mbp_pkg::S_QNEXT;
				end
			end
			mbp_pkg::S_QNEXT:
			begin
				// Walk the address list in order
				if (idx_q == len_q)
					st_d = mbp_pkg::S_FINISH;
				else
				begin
					qblk_d  = 8'(blk(base_q, mbp_pkg::W_LIST + idx_q[7:0]));
					qstop_d = 1'(blk(qblk_d, mbp_pkg::QB_FLAGS) >> mbp_pkg::QF_STOP_EXC);
					slv_d   = 8'(blk(qblk_d, mbp_pkg::QB_SLAVE));
					fn_d    = 8'(blk(qblk_d, mbp_pkg::QB_FUNC));
					start_d = 1'b1;
					sec_d   = 16'h0;
					cyc_d   = 32'h0;
					st_d    = mbp_pkg::S_QWAIT;
				end
			end
			mbp_pkg::S_QWAIT:
			begin
				// Seconds counter for the query timeout
				if (cyc_q == CYC_PER_SEC - 1)
				begin
					cyc_d = 32'h0;
					sec_d = sec_q + 16'h1;
				end
				else
					cyc_d = cyc_q + 32'h1;
				if (halt)
				begin
					code_d = mbp_pkg::ERR_QUERY;
					st_d   = mbp_pkg::S_ERRLOC;
				end
				else if (QRY_DONE_I || fail)
				begin
					idx_d = idx_q + 16'h1;
					st_d  = mbp_pkg::S_QNEXT;
				end
			end
			mbp_pkg::S_ERRLOC:
			begin
				// Record the offending query block
				fsm_we = 1'b1;
				fsm_wa = base_q + mbp_pkg::W_ERRLOC;
				fsm_wd = {8'h0, qblk_q};
				st_d   = mbp_pkg::S_FINISH;
			end
			mbp_pkg::S_FINISH:
			begin
				// Completion code goes to the error word
				fsm_we = 1'b1;
				fsm_wa = base_q + mbp_pkg::W_ERR;
				fsm_wd = code_q;
				err_d  = code_q != mbp_pkg::ERR_NONE;
				busy_d = code_q != mbp_pkg::ERR_NONE; // On error, busy held until acknowledged
				st_d   = mbp_pkg::S_IDLE;
			end
		endcase
	end

	// Block memory: bus writes never collide, the bus stalls instead
	always_ff @(posedge REF_CLK_I)
	begin
		if (fsm_we)
			mem_q[fsm_wa] <= fsm_wd;
		else if (apb_go && PWRITE_I && mem_hit)
			mem_q[PADDR_I[9:2]] <= PWDATA_I[15:0];
	end

	// State registers
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			st_q     <= mbp_pkg::S_IDLE;
			cfg_q    <= '0;
			ctrl_q   <= mbp_pkg::CTRL_RST;
			prdata_q <= 32'h0;
			base_q   <= 8'h0;
			idx_q    <= 16'h0;
			len_q    <= 16'h0;
			stop_q   <= 1'b0;
			qstop_q  <= 1'b0;
			tmo_q    <= 16'h0;
			sec_q    <= 16'h0;
			cyc_q    <= 32'h0;
			code_q   <= mbp_pkg::ERR_NONE;
			busy_q   <= 1'b0;
			err_q    <= 1'b0;
			armed_q  <= 1'b0;
			start_q  <= 1'b0;
			qblk_q   <= 8'h0;
			slv_q    <= 8'h0;
			fn_q     <= 8'h0;
		end
		else
		begin
			st_q     <= st_d;
			cfg_q    <= cfg_d;
			ctrl_q   <= ctrl_d;
			prdata_q <= prdata_d;
			base_q   <= base_d;
			idx_q    <= idx_d;
			len_q    <= len_d;
			stop_q   <= stop_d;
			qstop_q  <= qstop_d;
			tmo_q    <= tmo_d;
			sec_q    <= sec_d;
			cyc_q    <= cyc_d;
			code_q   <= code_d;
			busy_q   <= busy_d;
			err_q    <= err_d;
			armed_q  <= armed_d;
			start_q  <= start_d;
			qblk_q   <= qblk_d;
			slv_q    <= slv_d;
			fn_q     <= fn_d;
		end
	end

	// Outputs, all from flip-flops except the bus handshake and the POLL_RUN_O state decode
	assign QRY_START_O  = start_q;
	assign QRY_BLOCK_O  = qblk_q;
	assign QRY_SLAVE_O  = slv_q;
	assign QRY_FUNC_O   = fn_q;
	assign CONN_UP_O    = cfg_q.up;
	assign PORT_NUM_O   = cfg_q.port;
	assign BAUD_O       = cfg_q.baud;
	assign PARITY_O     = cfg_q.parity;
	assign RS485_O      = cfg_q.rs485;
	assign STD_TIMING_O = cfg_q.std_timing;
	assign MODEM_EN_O   = cfg_q.modem_en;
	assign MODEM_TAB_O  = cfg_q.modem_tab;
	assign POLL_RUN_O   = (st_q == mbp_pkg::S_QWAIT);
endmodule
`default_nettype wire

// >>> verif/mbp_poll_monitor.sv
// Port-level concurrent checks for the poll list interpreter
`timescale 1ns/1ps
`default_nettype none
module mbp_poll_monitor (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic        PREADY_O,
	input  wire logic        PSLVERR_O,
	input  wire logic        QRY_START_O,
	input  wire logic [7:0]  QRY_BLOCK_O,
	input  wire logic        POLL_RUN_O,
	input  wire logic        CONN_UP_O,
	input  wire logic [15:0] PORT_NUM_O,
	input  wire logic [15:0] BAUD_O,
	input  wire logic [1:0]  PARITY_O,
	input  wire logic        MODEM_EN_O,
	input  wire logic [15:0] MODEM_TAB_O
);
	logic mapped; // Register or memory window hit
	assign mapped = (PADDR_I[11:10] == mbp_pkg::MEM_SEL) || (PADDR_I == mbp_pkg::CTRL_OFS)
		|| (PADDR_I == mbp_pkg::STAT_OFS) || (PADDR_I == mbp_pkg::CFG_OFS);
	// One clock domain, so shared clocking and reset
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	a_start_pulse:
		assert property (QRY_START_O |=> !QRY_START_O)
		else $error("query start held past one cycle");
	a_start_waits:
		assert property (QRY_START_O |=> POLL_RUN_O)
		else $error("query start without wait");
	a_block_hold:
		assert property (POLL_RUN_O && !QRY_START_O |-> $stable(QRY_BLOCK_O))
		else $error("query block moved during wait");
	a_parity_code:
		assert property (PARITY_O != 2'h3)
		else $error("parity code out of range");
	a_port_range:
		assert property (CONN_UP_O |-> PORT_NUM_O inside {[16'h0001:mbp_pkg::NUM_PORTS]})
		else $error("bound port out of range");
	a_baud_set:
		assert property (CONN_UP_O |-> BAUD_O != 16'h0000)
		else $error("connection with zero rate");
	a_modem_table:
		assert property (MODEM_TAB_O == 16'h0000 |-> !MODEM_EN_O)
		else $error("modem used without table");
	a_cfg_frozen:
		assert property (POLL_RUN_O |=> $stable({PORT_NUM_O, BAUD_O, PARITY_O}))
		else $error("settings changed while polling");
	a_poll_conn:
		assert property (!CONN_UP_O |-> !QRY_START_O)
		else $error("query started with no connection");
	a_ready_bound:
		assert property (PSEL_I && PENABLE_I |-> ##[0:2] PREADY_O)
		else $error("bus stall too long");
	a_unmapped_err:
		assert property (PSEL_I && PENABLE_I && PREADY_O && !mapped |-> PSLVERR_O)
		else $error("unmapped access not refused");
endmodule
bind mbp_poll_list mbp_poll_monitor mon_u (.*);
`default_nettype wire

// >>> verif/mbp_rtu_model.sv
// Behavioural RTU engine with a fixed slave population
`timescale 1ns/1ps
`default_nettype none
module mbp_rtu_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [7:0] slave_i,
	output logic            done_o,
	output logic      [1:0] status_o
);
	int         cnt; // Cycles left to the answer
	logic [7:0] sl;  // Slave being served
	// Slave 1 ok, 2 exception, 3 bad frame, 4 silent; latency grows with address
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt <= 0;
			sl <= 8'h00;
			done_o <= 1'b0;
			status_o <= 2'h3;
		end
		else
		begin
			done_o <= 1'b0;
			// Garbage outside the answer cycle, never a held value
			status_o <= ~status_o;
			if (start_i)
			begin
				cnt <= 2 * int'(slave_i) + 1;
				sl <= slave_i;
			end
			else if (cnt > 0)
				cnt <= cnt - 1;
			// Silent slave never answers, forcing a timeout
			if (!start_i && cnt == 1 && sl != 8'h04)
			begin
				done_o <= 1'b1;
				if (sl == 8'h01)
					status_o <= mbp_pkg::QS_OK;
				else if (sl == 8'h02)
					status_o <= mbp_pkg::QS_EXC;
				else
					status_o <= mbp_pkg::QS_PROTO;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the poll list interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int CPS = 20; // Short second keeps runs brief
	logic        clk, rst_n, psel, pen, pwr, rdy, serr, qs, run, done, e, rs, stdt, mdm;
	logic [11:0] addr;
	logic [31:0] wdat, prd, rdat;
	logic [7:0]  qsl, qfn;
	logic [1:0]  qst;
	int          n_errors, checks_done, n_starts, n_run, r0;
	logic [15:0] cb [12] = '{16'h0, 16'h1, 16'h4b17, 16'h28, 16'h3, 16'h2580, 16'h0, 16'h0, 16'h0,
		16'h0, 16'h0, 16'h0};
	mbp_poll_list #(.CYC_PER_SEC(CPS)) dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(prd),
		.PREADY_O(rdy), .PSLVERR_O(serr), .QRY_START_O(qs), .QRY_BLOCK_O(), .QRY_SLAVE_O(qsl),
		.QRY_FUNC_O(qfn), .QRY_DONE_I(done), .QRY_STATUS_I(qst), .CONN_UP_O(), .PORT_NUM_O(),
		.BAUD_O(), .PARITY_O(), .RS485_O(rs), .STD_TIMING_O(stdt), .MODEM_EN_O(mdm), .MODEM_TAB_O(),
		.POLL_RUN_O(run));
	mbp_rtu_model rtu_u (.clk_i(clk), .rst_n_i(rst_n), .start_i(qs), .slave_i(qsl),
		.done_o(done), .status_o(qst));
	// Clock at 25 MHz
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Query starts and wait cycles seen
	always @(posedge clk)
	begin
		if (qs === 1'b1)
			n_starts++;
		if (run === 1'b1)
			n_run++;
	end
	// APB master: hold request until pready sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		rdat = prd;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wm(input logic [7:0] n, input logic [15:0] v);
		apb(1'b1, {mbp_pkg::MEM_SEL, n, 2'h0}, {16'h0, v});
	endtask
	// Coupled trigger: low first, then high; poll status until idle or error
	task automatic trig(input logic [7:0] b);
		apb(1'b1, mbp_pkg::CTRL_OFS, {16'h0, b, 8'h02});
		apb(1'b1, mbp_pkg::CTRL_OFS, {16'h0, b, 8'h03});
		repeat (60)
		begin
			apb(1'b0, mbp_pkg::STAT_OFS, 32'h0);
			if (rdat[0] !== 1'b1 || rdat[1] === 1'b1)
				break;
		end
	endtask
	// Acknowledge with trigger low
	task automatic ack();
		apb(1'b1, mbp_pkg::CTRL_OFS, 32'h4);
		apb(1'b0, mbp_pkg::STAT_OFS, 32'h0);
		chk({30'h0, rdat[1:0]}, 32'h0, "ack flags");
		apb(1'b1, mbp_pkg::CTRL_OFS, 32'h0);
	endtask
	// Poll block at word 0x40 with up to two list entries
	task automatic poll(input logic [15:0] fl, cn, ln, l0, l1, input logic [31:0] st, input int ns,
		input logic [15:0] loc);
		int s0;
		wm(8'h41, mbp_pkg::CMD_POLL);
		wm(8'h42, cn);
		wm(8'h43, fl);
		wm(8'h44, 16'h1);
		wm(8'h45, 16'h0);
		wm(8'h46, ln);
		wm(8'h47, l0);
		wm(8'h48, l1);
		wm(8'h49, 16'h0); // Spare list word kept zero
		s0 = n_starts;
		trig(8'h40);
		chk(rdat, st, "poll status");
		chk({24'h0, qfn}, 32'h3, "query function");
		chk(32'(n_starts - s0), 32'(ns), "query count");
		apb(1'b0, {mbp_pkg::MEM_SEL, 8'h45, 2'h0}, 32'h0);
		chk(rdat, {16'h0, loc}, "error location");
		apb(1'b0, {mbp_pkg::MEM_SEL, 8'h40, 2'h0}, 32'h0);
		chk(rdat, {16'h0, st[31:16]}, "error word");
		if (st[1])
			ack();
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (30000) @(posedge clk);
		n_errors++;
		end_sim();
	end
	initial
	begin
		{psel, pen, pwr, addr, wdat, n_errors, checks_done, n_starts, n_run} = '0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, mbp_pkg::STAT_OFS, 32'h0);
		chk(rdat, 32'h0, "status reset");
		apb(1'b0, mbp_pkg::CFG_OFS, 32'h0);
		chk(rdat, 32'h0, "settings reset");
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped refused");
		$display("test reset done");
		for (int i = 0; i < 12; i++)
			wm(8'h10 + 8'(i), cb[i]); // Reserved words zeroed
		for (int p = 0; p < 3; p++)
		begin
			wm(8'h17, 16'(p));
			wm(8'h19, (p == 1) ? mbp_pkg::HS_RS485 : mbp_pkg::HS_NONE);
			wm(8'h1a, (p == 0) ? 16'h0 : 16'h1); // Option bits set on later passes
			wm(8'h1b, (p == 2) ? 16'h0100 : 16'h0); // Modem table only on the last pass
			trig(8'h10);
			chk(rdat, 32'h0, "create status");
			apb(1'b0, mbp_pkg::CFG_OFS, 32'h0);
			chk(rdat, {16'h2580, 8'h03, 2'h1, p == 2, p == 0, p == 1, 3'(p)}, "settings");
			chk({29'h0, rs, stdt, mdm}, {29'h0, p == 1, p == 0, p == 2}, "line pins");
		end
		wm(8'h13, 16'h0029);
		trig(8'h10);
		chk(rdat, 32'h0002_0003, "bad handler");
		ack();
		wm(8'h13, mbp_pkg::HANDLER_RTU);
		trig(8'h10);
		chk(rdat, 32'h0, "create after ack");
		$display("test create done");
		// Query blocks: slave n at word 0x70 + 16n, exception stop on slave 2
		for (int i = 1; i < 5; i++)
		begin
			wm(8'h71 + 8'(16 * i), (i == 2) ? 16'h2 : 16'h0);
			wm(8'h74 + 8'(16 * i), 16'(i));
			wm(8'h75 + 8'(16 * i), 16'h3);
			wm(8'h77 + 8'(16 * i), 16'h006b); // Start register sent zero-relative
		end
		poll(16'h1, 16'h4b17, 16'h2, 16'h80, 16'h90, 32'h0005_0003, 2, 16'h90);
		poll(16'h1, 16'h4b17, 16'h2, 16'ha0, 16'h80, 32'h0005_0003, 1, 16'ha0);
		poll(16'h0, 16'h4b17, 16'h2, 16'ha0, 16'h80, 32'h0, 2, 16'h0);
		r0 = n_starts;
		repeat (40) @(posedge clk);
		chk(32'(n_starts - r0), 32'h0, "coupled rerun");
		r0 = n_run;
		poll(16'h1, 16'h4b17, 16'h1, 16'hb0, 16'h80, 32'h0005_0003, 1, 16'hb0);
		chk({31'h0, n_run - r0 >= CPS && n_run - r0 <= CPS + 3}, 32'h1, "timeout span");
		poll(16'h1, 16'h4b18, 16'h2, 16'h80, 16'h90, 32'h0004_0003, 0, 16'h0);
		$display("test poll done");
		end_sim();
	end
endmodule
`default_nettype wire
